// *** logic/lcdcd_cfg.svh ***
// constants of the display command decoder: opcodes, fields, reset values
// assumes inclusion by bare name from the decoder and its memory
`ifndef LCDCD_CFG_SVH
`define LCDCD_CFG_SVH

// command opcodes, bit 0 of the pair opcodes is the setting
`define LCDCD_CMD_DISP_ONOFF   8'hae
`define LCDCD_CMD_POLARITY     8'ha6
`define LCDCD_CMD_ALL_LIT      8'ha4
`define LCDCD_CMD_COM_DIR      8'hc4
`define LCDCD_CMD_START_LINE   8'h8a
`define LCDCD_CMD_PAGE_SET     8'hb1
`define LCDCD_CMD_COL_SET      8'h13
`define LCDCD_CMD_DATA_WR      8'h1d
`define LCDCD_CMD_DATA_RD      8'h1c

// field positions
`define LCDCD_SEL_BIT          0
`define LCDCD_PAGE_FIELD_MSB   4
`define LCDCD_PAGE_FIELD_LSB   0

// reset values
`define LCDCD_RST_PANEL_ON     1'b0
`define LCDCD_RST_INVERSE      1'b0
`define LCDCD_RST_ALL_LIT      1'b0
`define LCDCD_RST_COM_REVERSE  1'b0
`define LCDCD_RST_START_LINE   8'h00
`define LCDCD_RST_PAGE         5'h00
`define LCDCD_RST_COL          8'h00
`define LCDCD_RST_BYTE         8'h00

// geometry
`define LCDCD_PAGE_LAST        5'h14
`define LCDCD_LINES_GRAY       8'h50
`define LCDCD_LINES_BIN        8'ha0
`define LCDCD_COM_LAST         7'h4f
`define LCDCD_ICON_ROW         8'h50

`endif

// *** logic/lcdcd_pkg.sv ***
// types shared by the display command decoder
// assumes nothing beyond a SystemVerilog compiler
package lcdcd_pkg;

  // what the next host byte with the select pin high means
  typedef enum logic [2:0]
  {
    ST_IDLE,
    ST_START_PARAM,
    ST_PAGE_PARAM,
    ST_COL_PARAM,
    ST_WR_DATA,
    ST_RD_DATA
  } lcdcd_state_e;

  typedef logic [7:0] lcdcd_byte_t;

endpackage : lcdcd_pkg

// *** logic/lcdcd_mem_if.sv ***
// carrier between the decoder and its display memory
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface lcdcd_mem_if #(
  parameter int ADDR_W = 13
);
  logic              wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [7:0]        wr_data;
  logic              rd_en;
  logic [ADDR_W-1:0] rd_addr;
  logic [7:0]        rd_data;

  modport client
  (
    output wr_en,
    output wr_addr,
    output wr_data,
    output rd_en,
    output rd_addr,
    input  rd_data
  );

  modport memory
  (
    input  wr_en,
    input  wr_addr,
    input  wr_data,
    input  rd_en,
    input  rd_addr,
    output rd_data
  );
endinterface : lcdcd_mem_if

// *** logic/lcdcd_ram.sv ***
// display memory: one write port, one read port with registered data
// assumes the client holds rd_en for one cycle per fetch
`timescale 1ns/1ns
module lcdcd_ram #(
  parameter int ADDR_W = 13
)(
  // clock and reset
  input  wire logic mclk,
  input  wire logic rstn,
  // access ports
  lcdcd_mem_if.memory mem
);
  `include "lcdcd_cfg.svh"

  logic [7:0] store [0:(1<<ADDR_W)-1];
  logic [7:0] rd_data_ff;

  // contents carry no reset, as on a real panel memory
  always_ff @(posedge mclk)
  begin
    if (mem.wr_en)
      store[mem.wr_addr] <= mem.wr_data;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      rd_data_ff <= `LCDCD_RST_BYTE;
    else if (mem.rd_en)
      rd_data_ff <= store[mem.rd_addr];
  end

  assign mem.rd_data = rd_data_ff;

endmodule : lcdcd_ram

// *** logic/lcdcd_decoder.sv ***
// display command decoder: host byte interpreter, address counters,
// display settings and a scan-side pixel and common mapper
// assumes host strobes are one-cycle pulses synchronous to mclk
`timescale 1ns/1ns

// Overview of operation
// - display on/off opcode pair, bit 0 turns panel drive on.
// - reset leaves panel drive off until the enabling command.
// - polarity opcode pair, bit 0 lights pixels whose memory bit is zero.
// - all-lit opcode pair forces every pixel lit before polarity applies, memory untouched.
// - reset selects normal memory-based output, not all-lit.
// - common direction opcode pair, up or down, icon line always last.
// - start line command takes the next parameter byte whole.
// - displayed rows walk upward from the start line, scrolling on change.
// - reset clears the start line to zero.
// - page command takes the low five bits of its parameter.
// - reset clears the page address to zero.
// - column command takes its whole parameter byte as column.
// - reset clears the column address to zero.
// - after write command each data byte is stored, address advances.
// - after read command each data read returns a byte, address advances.
// - first read after an address change returns stale latch data.
// - serial host mode has no read path.
// - don't-care parameter bits never reach any stored setting.
// - select pin plus strobes classify command, parameter or data.
module lcdcd_decoder #(
  parameter int PAGE_W = 5,
  parameter int COL_W  = 8,
  parameter int LINE_W = 8
)(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // host byte bus
  input  wire logic              host_wr_stb,
  input  wire logic              host_rd_stb,
  input  wire logic              cmd_data_select,
  input  wire logic [7:0]        host_din,
  output      logic [7:0]        host_dout,
  output      logic              host_dout_en,
  // configuration pins
  input  wire logic              serial_mode,
  input  wire logic              page_direction,
  input  wire logic              binary_mode,
  // settings seen by the panel drivers
  output      logic              panel_on,
  output      logic              inverse_on,
  output      logic              all_lit_on,
  output      logic              com_reverse,
  output      logic [LINE_W-1:0] start_line_field,
  output      logic [PAGE_W-1:0] page_field,
  output      logic [COL_W-1:0]  column_field,
  // scan side
  input  wire logic [7:0]        scan_row,
  input  wire logic              scan_mem_bit,
  output      logic [LINE_W-1:0] scan_line,
  output      logic              scan_pixel,
  output      logic [6:0]        scan_common,
  output      logic              icon_common_line
);
  `include "lcdcd_cfg.svh"

  localparam int ADDR_W = PAGE_W + COL_W;

  // pair opcodes differ only in the setting bit
  function automatic logic is_pair(input logic [7:0] b,
                                   input logic [7:0] base);
    is_pair = (b[7:1] == base[7:1]);
  endfunction : is_pair

  // wraps after the last page so auto-advance never leaves the memory
  function automatic logic [PAGE_W-1:0] page_step(
    input logic [PAGE_W-1:0] p);
    if (p == PAGE_W'(`LCDCD_PAGE_LAST))
      page_step = '0;
    else
      page_step = p + PAGE_W'(1);
  endfunction : page_step

  // a parameter byte arriving while a given command waits for it
  function automatic logic param_for(input logic stb,
                                     input lcdcd_pkg::lcdcd_state_e cur,
                                     input lcdcd_pkg::lcdcd_state_e want);
    param_for = stb && (cur == want);
  endfunction : param_for

  // registers
  lcdcd_pkg::lcdcd_state_e state_ff;
  lcdcd_pkg::lcdcd_state_e nxt_state;
  logic                    panel_on_ff;
  logic                    inverse_ff;
  logic                    all_lit_ff;
  logic                    com_reverse_ff;
  logic [LINE_W-1:0]       start_line_ff;
  logic [PAGE_W-1:0]       page_ff;
  logic [COL_W-1:0]        col_ff;
  logic [7:0]              rd_latch_ff;
  logic                    fetch_pend_ff;
  logic [7:0]              host_dout_ff;
  logic                    dout_en_ff;
  logic [LINE_W-1:0]       scan_line_ff;
  logic                    scan_pixel_ff;
  logic [6:0]              scan_common_ff;
  logic                    icon_ff;

  // decoded transfers
  logic cmd_wr;
  logic param_wr;
  logic data_rd;
  logic do_write;
  logic do_read;
  logic advance;
  logic [7:0] cur_latch;
  logic [LINE_W:0] line_sum;
  logic [LINE_W:0] line_lim;

  lcdcd_mem_if #(.ADDR_W(ADDR_W)) mem ();

  lcdcd_ram #(.ADDR_W(ADDR_W)) u_ram
  (
    .mclk (mclk),
    .rstn (rstn),
    .mem  (mem.memory)
  );

  // command when select is low, parameter or data when high
  assign cmd_wr   = host_wr_stb & ~cmd_data_select;
  assign param_wr = host_wr_stb &  cmd_data_select;
  assign data_rd  = host_rd_stb &  cmd_data_select;

  assign do_write = param_wr & (state_ff == lcdcd_pkg::ST_WR_DATA);
  // serial hosts get no read path at all
  assign do_read  = data_rd & ~serial_mode
                  & (state_ff == lcdcd_pkg::ST_RD_DATA);
  assign advance  = do_write | do_read;

  // the fetch issued by the previous read lands this cycle
  assign cur_latch = fetch_pend_ff ? mem.rd_data : rd_latch_ff;

  // which meaning the next parameter byte carries
  always_comb
  begin
    nxt_state = state_ff;
    if (cmd_wr)
    begin
      case (host_din)
        `LCDCD_CMD_START_LINE: nxt_state = lcdcd_pkg::ST_START_PARAM;
        `LCDCD_CMD_PAGE_SET:   nxt_state = lcdcd_pkg::ST_PAGE_PARAM;
        `LCDCD_CMD_COL_SET:    nxt_state = lcdcd_pkg::ST_COL_PARAM;
        `LCDCD_CMD_DATA_WR:    nxt_state = lcdcd_pkg::ST_WR_DATA;
        `LCDCD_CMD_DATA_RD:    nxt_state = lcdcd_pkg::ST_RD_DATA;
        default:               nxt_state = lcdcd_pkg::ST_IDLE;
      endcase
    end
    else if (param_wr)
    begin
      // one parameter binds to the command just before it
      case (state_ff)
        lcdcd_pkg::ST_START_PARAM: nxt_state = lcdcd_pkg::ST_IDLE;
        lcdcd_pkg::ST_PAGE_PARAM:  nxt_state = lcdcd_pkg::ST_IDLE;
        lcdcd_pkg::ST_COL_PARAM:   nxt_state = lcdcd_pkg::ST_IDLE;
        lcdcd_pkg::ST_WR_DATA:     nxt_state = lcdcd_pkg::ST_WR_DATA;
        lcdcd_pkg::ST_RD_DATA:     nxt_state = lcdcd_pkg::ST_RD_DATA;
        default:                   nxt_state = lcdcd_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      state_ff <= lcdcd_pkg::ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // display settings
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      panel_on_ff    <= `LCDCD_RST_PANEL_ON;
      inverse_ff     <= `LCDCD_RST_INVERSE;
      all_lit_ff     <= `LCDCD_RST_ALL_LIT;
      com_reverse_ff <= `LCDCD_RST_COM_REVERSE;
    end
    else if (cmd_wr)
    begin
      if (is_pair(host_din, `LCDCD_CMD_DISP_ONOFF))
        panel_on_ff <= host_din[`LCDCD_SEL_BIT];
      if (is_pair(host_din, `LCDCD_CMD_POLARITY))
        inverse_ff <= host_din[`LCDCD_SEL_BIT];
      if (is_pair(host_din, `LCDCD_CMD_ALL_LIT))
        all_lit_ff <= host_din[`LCDCD_SEL_BIT];
      if (is_pair(host_din, `LCDCD_CMD_COM_DIR))
        com_reverse_ff <= host_din[`LCDCD_SEL_BIT];
    end
  end

  // start line; range limits are the host's to keep
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      start_line_ff <= `LCDCD_RST_START_LINE;
    else if (param_for(param_wr, state_ff, lcdcd_pkg::ST_START_PARAM))
      start_line_ff <= host_din[LINE_W-1:0];
  end

  // page address: parameter or auto-advance in page direction
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      page_ff <= `LCDCD_RST_PAGE;
    else if (param_for(param_wr, state_ff, lcdcd_pkg::ST_PAGE_PARAM))
      page_ff <= host_din[`LCDCD_PAGE_FIELD_MSB:
                          `LCDCD_PAGE_FIELD_LSB];
    else if (advance && page_direction)
      page_ff <= page_step(page_ff);
  end

  // column address: parameter or auto-advance in column direction
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      col_ff <= `LCDCD_RST_COL;
    else if (param_for(param_wr, state_ff, lcdcd_pkg::ST_COL_PARAM))
      col_ff <= host_din[COL_W-1:0];
    else if (advance && !page_direction)
      col_ff <= col_ff + COL_W'(1);
  end

  // memory ports
  assign mem.wr_en   = do_write;
  assign mem.wr_addr = {page_ff, col_ff};
  assign mem.wr_data = host_din;
  assign mem.rd_en   = do_read;
  assign mem.rd_addr = {page_ff, col_ff};

  // read pipeline: a read hands out the latch, then refills it from the
  // current address, so the first read after a move is stale
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      fetch_pend_ff <= 1'b0;
    else
      fetch_pend_ff <= do_read;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      rd_latch_ff <= `LCDCD_RST_BYTE;
    else if (fetch_pend_ff)
      rd_latch_ff <= mem.rd_data;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      host_dout_ff <= `LCDCD_RST_BYTE;
    else if (do_read)
      host_dout_ff <= cur_latch;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      dout_en_ff <= 1'b0;
    else
      dout_en_ff <= do_read;
  end

  // scan side: row to memory line, wrapping at the memory height
  // one subtraction is enough while the host keeps the start line in range
  assign line_sum = {1'b0, start_line_ff} + {1'b0, scan_row[LINE_W-1:0]};
  assign line_lim = binary_mode ? {1'b0, `LCDCD_LINES_BIN}
                                : {1'b0, `LCDCD_LINES_GRAY};

  always_ff @(posedge mclk)
  begin
    if (!rstn)
      scan_line_ff <= `LCDCD_RST_START_LINE;
    else if (line_sum >= line_lim)
      scan_line_ff <= LINE_W'(line_sum - line_lim);
    else
      scan_line_ff <= line_sum[LINE_W-1:0];
  end

  // pixel level: all-lit wins over memory, polarity applies last so
  // all-lit plus inverse gives a blank panel; drive off blanks all
  always_ff @(posedge mclk)
  begin
    if (!rstn)
      scan_pixel_ff <= 1'b0;
    else
      scan_pixel_ff <= panel_on_ff
                     & ((all_lit_ff | scan_mem_bit) ^ inverse_ff);
  end

  // common select: icon line always scanned after the last common
  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      scan_common_ff <= '0;
      icon_ff        <= 1'b0;
    end
    else if (scan_row >= `LCDCD_ICON_ROW)
    begin
      scan_common_ff <= '0;
      icon_ff        <= 1'b1;
    end
    else
    begin
      icon_ff        <= 1'b0;
      scan_common_ff <= com_reverse_ff
                      ? (`LCDCD_COM_LAST - scan_row[6:0])
                      : scan_row[6:0];
    end
  end

  // outputs
  assign host_dout        = host_dout_ff;
  assign host_dout_en     = dout_en_ff;
  assign panel_on         = panel_on_ff;
  assign inverse_on       = inverse_ff;
  assign all_lit_on       = all_lit_ff;
  assign com_reverse      = com_reverse_ff;
  assign start_line_field = start_line_ff;
  assign page_field       = page_ff;
  assign column_field     = col_ff;
  assign scan_line        = scan_line_ff;
  assign scan_pixel       = scan_pixel_ff;
  assign scan_common      = scan_common_ff;
  assign icon_common_line = icon_ff;

endmodule : lcdcd_decoder

// *** bench/lcdcd_asserts.sv ***
// port assertions for the display command decoder
// assumes a bind onto lcdcd_decoder with its parameters
`timescale 1ns/1ns
module lcdcd_asserts #(
  parameter int PAGE_W = 5,
  parameter int COL_W  = 8,
  parameter int LINE_W = 8
)(
  // clock and reset
  input wire logic              mclk,
  input wire logic              rstn,
  // host bus
  input wire logic              host_wr_stb,
  input wire logic              host_rd_stb,
  input wire logic              cmd_data_select,
  input wire logic [7:0]        host_din,
  input wire logic              host_dout_en,
  input wire logic              serial_mode,
  input wire logic              binary_mode,
  // settings
  input wire logic              panel_on,
  input wire logic              inverse_on,
  input wire logic              all_lit_on,
  input wire logic              com_reverse,
  input wire logic [LINE_W-1:0] start_line_field,
  input wire logic [PAGE_W-1:0] page_field,
  input wire logic [COL_W-1:0]  column_field,
  // scan side
  input wire logic [7:0]        scan_row,
  input wire logic              scan_mem_bit,
  input wire logic [LINE_W-1:0] scan_line,
  input wire logic              scan_pixel,
  input wire logic [6:0]        scan_common,
  input wire logic              icon_common_line
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  wire cmd_stb = host_wr_stb && !cmd_data_select;

  a_panel_cmd:
    assert property (cmd_stb && host_din[7:1] == 7'h57 |=>
      panel_on == $past(host_din[0])) else $error("panel drive wrong");
  a_polarity_cmd:
    assert property (cmd_stb && host_din[7:1] == 7'h53 |=>
      inverse_on == $past(host_din[0])) else $error("polarity wrong");
  a_all_lit_cmd:
    assert property (cmd_stb && host_din[7:1] == 7'h52 |=>
      all_lit_on == $past(host_din[0])) else $error("all-lit wrong");
  a_com_dir_cmd:
    assert property (cmd_stb && host_din[7:1] == 7'h62 |=>
      com_reverse == $past(host_din[0])) else $error("direction wrong");
  a_reset_state:
    assert property (disable iff (1'b0) !rstn |=> !panel_on && !inverse_on
      && !all_lit_on && !com_reverse && start_line_field == '0
      && page_field == '0 && column_field == '0) else $error("reset state");
  a_pixel_map:
    assert property (1'b1 |=> scan_pixel == $past(panel_on &
      ((all_lit_on | scan_mem_bit) ^ inverse_on))) else $error("pixel");
  a_common_map:
    assert property (scan_row < 8'h50 |=> !icon_common_line &&
      scan_common == ($past(com_reverse) ? 7'h4f - $past(scan_row[6:0])
      : $past(scan_row[6:0]))) else $error("common index wrong");
  a_icon_last:
    assert property (scan_row >= 8'h50 |=> icon_common_line &&
      scan_common == 7'h00) else $error("icon common wrong");
  a_line_wrap:
    assert property (scan_row < 8'h50 |=> scan_line == ($past(
      start_line_field) + $past(scan_row)) % ($past(binary_mode) ? 160 : 80))
      else $error("scan line wrong");
  a_stray_read:
    assert property (host_rd_stb && (serial_mode || !cmd_data_select) |=>
      !host_dout_en) else $error("refused read answered");
  a_addr_hold:
    assert property (!host_wr_stb && !host_rd_stb |=> $stable(column_field)
      && $stable(page_field)) else $error("address moved idle");
endmodule : lcdcd_asserts

// *** bench/lcdcd_host_bfm.sv ***
// host processor model: byte writes and reads on the strobe bus
// assumes the bench calls put and get from one sequence
`timescale 1ns/1ns
module lcdcd_host_bfm (
  // clock
  input  wire logic       mclk,
  // strobe bus
  output      logic       wr_stb,
  output      logic       rd_stb,
  output      logic       sel,
  output      logic [7:0] din,
  input  wire logic [7:0] dout,
  input  wire logic       dout_en
);
  initial
  begin
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    sel    = 1'b0;
    din    = 8'h00;
  end

  // released bus shows the inverted byte, so a late sample never matches
  task automatic put(input logic s, input logic [7:0] d);
    logic [7:0] sh;
    sh = 8'h00;
    // host bit order: most significant bit leaves first
    for (int i = 7; i >= 0; i--)
      sh = {sh[6:0], d[i]};
    @(negedge mclk);
    sel    = s;
    din    = sh;
    wr_stb = 1'b1;
    @(negedge mclk);
    wr_stb = 1'b0;
    din    = ~sh;
  endtask : put

  task automatic get(output logic [7:0] d, output logic en);
    @(negedge mclk);
    sel    = 1'b1;
    rd_stb = 1'b1;
    @(negedge mclk);
    rd_stb = 1'b0;
    d      = dout;
    en     = dout_en;
  endtask : get
endmodule : lcdcd_host_bfm

// *** bench/lcd_display_command_decoder_tb.sv ***
// top bench of the display command decoder
// assumes lcdcd_host_bfm drives the host bus
`timescale 1ns/1ns
module lcd_display_command_decoder_tb;
  logic       mclk = 1'b0;
  logic       rstn = 1'b0;
  logic       wr_stb, rd_stb, sel, dout_en, rd_en, pixel, icon;
  logic       panel_on, inverse_on, all_lit_on, com_rev;
  logic       serial = 1'b0, page_dir = 1'b0, bin = 1'b0, mem_bit = 1'b0;
  logic [7:0] din, dout, rd_val, start_line, column, scan_line;
  logic [7:0] scan_row = 8'h00;
  logic [4:0] page;
  logic [6:0] common;
  logic [3:0] flags;
  logic [7:0] ops [4] = '{8'hae, 8'ha6, 8'ha4, 8'hc4};
  logic [7:0] wdat [3] = '{8'haa, 8'h55, 8'hc3};
  int         bad_count = 0;
  int         total_checks = 0;

  always #10 mclk = ~mclk;

  lcdcd_decoder u_dut (
    .mclk(mclk), .rstn(rstn), .host_wr_stb(wr_stb), .host_rd_stb(rd_stb),
    .cmd_data_select(sel), .host_din(din), .host_dout(dout),
    .host_dout_en(dout_en), .serial_mode(serial), .page_direction(page_dir),
    .binary_mode(bin), .panel_on(panel_on), .inverse_on(inverse_on),
    .all_lit_on(all_lit_on), .com_reverse(com_rev),
    .start_line_field(start_line), .page_field(page), .column_field(column),
    .scan_row(scan_row), .scan_mem_bit(mem_bit), .scan_line(scan_line),
    .scan_pixel(pixel), .scan_common(common), .icon_common_line(icon));

  lcdcd_host_bfm u_host (
    .mclk(mclk), .wr_stb(wr_stb), .rd_stb(rd_stb), .sel(sel), .din(din),
    .dout(dout), .dout_en(dout_en));

  task automatic chk(input string what, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic scan(input logic [7:0] r, input logic m);
    @(negedge mclk);
    scan_row = r;
    mem_bit  = m;
    @(negedge mclk);
  endtask : scan

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results

  // whole sequence needs about a hundred cycles
  initial
  begin
    repeat (4000) @(posedge mclk);
    bad_count++;
    results();
  end

  initial
  begin
    repeat (6) @(negedge mclk);
    rstn = 1'b1;
    chk("flags", 8'h00, {4'h0, panel_on, inverse_on, all_lit_on, com_rev});
    chk("start", 8'h00, start_line);
    chk("page", 8'h00, {3'h0, page});
    chk("column", 8'h00, column);
    $display("test reset done");
    for (int i = 0; i < 4; i++)
      for (int b = 1; b >= 0; b--)
      begin
        u_host.put(1'b0, ops[i] | 8'(b));
        flags = {panel_on, inverse_on, all_lit_on, com_rev};
        chk("setting", 8'(b), {7'h0, flags[3-i]});
      end
    $display("test settings done");
    u_host.put(1'b0, 8'h8a);
    u_host.put(1'b1, 8'h4f);
    chk("start", 8'h4f, start_line);
    u_host.put(1'b0, 8'hb1);
    u_host.put(1'b1, 8'he3);
    chk("page", 8'h03, {3'h0, page});
    u_host.put(1'b0, 8'h13);
    u_host.put(1'b1, 8'hfe);
    chk("column", 8'hfe, column);
    u_host.put(1'b1, 8'h44);
    chk("column", 8'hfe, column);
    $display("test addresses done");
    u_host.put(1'b0, 8'h1d);
    foreach (wdat[k]) u_host.put(1'b1, wdat[k]);
    chk("column", 8'h01, column);
    u_host.put(1'b0, 8'h13);
    u_host.put(1'b1, 8'hfe);
    u_host.put(1'b0, 8'h1c);
    u_host.get(rd_val, rd_en);
    chk("dummy", 8'h01, {7'h0, rd_en});
    foreach (wdat[k])
    begin
      u_host.get(rd_val, rd_en);
      chk("read", wdat[k], rd_val);
    end
    chk("column", 8'h02, column);
    page_dir = 1'b1;
    u_host.put(1'b0, 8'hb1);
    u_host.put(1'b1, 8'h14);
    u_host.put(1'b0, 8'h1d);
    u_host.put(1'b1, 8'h5a);
    chk("page", 8'h00, {3'h0, page});
    chk("column", 8'h02, column);
    serial = 1'b1;
    u_host.put(1'b0, 8'h1c);
    u_host.get(rd_val, rd_en);
    chk("serial read", 8'h00, {7'h0, rd_en});
    serial = 1'b0;
    $display("test memory done");
    u_host.put(1'b0, 8'h8a);
    u_host.put(1'b1, 8'h4e);
    u_host.put(1'b0, 8'haf);
    scan(8'h03, 1'b1);
    chk("line", 8'h01, scan_line);
    chk("pixel", 8'h01, {7'h0, pixel});
    u_host.put(1'b0, 8'ha7);
    scan(8'h03, 1'b1);
    chk("pixel", 8'h00, {7'h0, pixel});
    u_host.put(1'b0, 8'ha5);
    scan(8'h03, 1'b0);
    chk("pixel", 8'h00, {7'h0, pixel});
    u_host.put(1'b0, 8'ha6);
    scan(8'h03, 1'b0);
    chk("pixel", 8'h01, {7'h0, pixel});
    u_host.put(1'b0, 8'hc5);
    scan(8'h05, 1'b0);
    chk("common", 8'h4a, {1'b0, common});
    scan(8'h50, 1'b0);
    chk("icon", 8'h80, {icon, common});
    bin = 1'b1;
    u_host.put(1'b0, 8'h8a);
    u_host.put(1'b1, 8'h9f);
    chk("start", 8'h9f, start_line);
    scan(8'h02, 1'b0);
    chk("line", 8'h01, scan_line);
    $display("test scan done");
    results();
  end
endmodule : lcd_display_command_decoder_tb

bind lcdcd_decoder lcdcd_asserts #(.PAGE_W(PAGE_W), .COL_W(COL_W),
  .LINE_W(LINE_W)) u_chk (.mclk, .rstn, .host_wr_stb, .host_rd_stb,
  .cmd_data_select, .host_din, .host_dout_en, .serial_mode, .binary_mode,
  .panel_on, .inverse_on, .all_lit_on, .com_reverse, .start_line_field,
  .page_field, .column_field, .scan_row, .scan_mem_bit, .scan_line,
  .scan_pixel, .scan_common, .icon_common_line);
